// >>> lpm_lcd_ladder.sv
// LCD reference ladder power scheduler, segment enables and pixel registers behind an AHB-Lite slave
//
// Operation
// - Interval A ladder power follows A select
// - Interval B ladder power follows B select
// - Ladder control bit 3 reads zero
// - Interval A length field; zero means always B
// - Type-A: N clocks A, 16-N B
// - Type-B: N clocks A, 32-N B
// - Set enable bit makes pin glass driver
// - Six segment-enable bytes cover segments 0-47
// - Reduced variant drops upper two enable bytes
// - Pixel bytes grouped six per backplane line
// - Reduced variant: upper pixel bytes are storage
// - Reduced variant: only bit 0 of segment-32 bytes
// - Pixel write when not allowed sets error
// - Waveform type chooses Type-A or Type-B
// - Inactive module switches ladder off
`timescale 1ns/1ps
module lpm_lcd_ladder
	import lpm_pkg::*;
#(
	parameter bit REDUCED_PINS = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic lcd_tick,
	input wire logic wave_transition,
	input wire logic module_active,
	input wire logic data_write_allowed,
	output logic [1:0] ladder_power,
	output logic in_interval_a,
	output logic [LPM_SEGS-1:0] glass_drive_on,
	output logic [LPM_LINES*LPM_SEGS-1:0] pixel_bit,
	output logic irq
);
	// Control registers
	logic [7:0] ladder_power_control;
	logic [7:0] control;
	logic [LPM_IRQ_BITS-1:0] irq_status;
	logic [LPM_IRQ_BITS-1:0] irq_mask;
	logic [7:0] seg_en [LPM_SEG_REGS];
	// Bus phase capture
	lpm_bus_state_t bus_state;
	lpm_bus_state_t next_bus_state;
	logic wr_pend;
	logic [7:0] addr_q;
	// Interval counter
	logic [4:0] interval_cnt;
	logic [4:0] next_interval_cnt;

	// Address phase decode
	wire logic addr_accept = hsel && htrans[1] && hready;
	wire logic rd_accept = addr_accept && !hwrite;
	wire logic wr_accept = addr_accept && hwrite;
	wire logic [7:0] ofs = addr_q;
	wire logic hit_ladder = (ofs == LPM_ADDR_LADDER);
	wire logic hit_control = (ofs == LPM_ADDR_CONTROL);
	wire logic hit_status = (ofs == LPM_ADDR_STATUS);
	wire logic hit_mask = (ofs == LPM_ADDR_IRQ_MASK);
	wire logic [7:0] seg_ofs = ofs - LPM_ADDR_SEG_BASE;
	wire logic [2:0] seg_index = seg_ofs[4:2];
	wire logic seg_limit = REDUCED_PINS ? (seg_index < 3'(LPM_REDUCED_SEG_REGS))
		: (seg_index < 3'(LPM_SEG_REGS));
	wire logic hit_seg = (ofs[7:5] == LPM_ADDR_SEG_BASE[7:5]) && (ofs[1:0] == 2'b00)
		&& (seg_index < 3'(LPM_SEG_REGS));
	wire logic seg_implemented = hit_seg && seg_limit;
	wire logic [7:0] pix_ofs = ofs - LPM_ADDR_PIX_BASE;
	wire logic [4:0] pix_index = pix_ofs[6:2];
	wire logic hit_pix = (ofs >= LPM_ADDR_PIX_BASE) && (ofs <= LPM_ADDR_PIX_LAST) && (ofs[1:0] == 2'b00);

	// Write strobes in the data phase
	wire logic wr_now = wr_pend && hreadyout;
	wire logic [7:0] wbyte = hwdata[7:0];
	wire logic pix_wr_try = wr_now && hit_pix;
	wire logic pix_wr_ok = pix_wr_try && data_write_allowed;
	wire logic pix_wr_refused = pix_wr_try && !data_write_allowed;

	// Reduced variant: segment-32 bytes keep only bit 0
	wire logic [2:0] pix_col = 3'(pix_index % 5'(LPM_SEG_REGS));
	wire logic pix_seg32_col = (pix_col == 3'd4);
	wire logic [7:0] pix_wmask = (REDUCED_PINS && pix_seg32_col) ? 8'h01 : 8'hFF;

	// Pixel storage
	logic [7:0] pix_rd;
	logic [LPM_PIX_REGS*8-1:0] pix_store;
	lpm_pixel_mem #(
		.DEPTH(LPM_PIX_REGS),
		.AW(5)
	) u_pix (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(pix_wr_ok),
		.wr_index(pix_index),
		.wr_data(wbyte & pix_wmask),
		.rd_index(pix_index),
		.rd_data(pix_rd),
		.contents(pix_store)
	);

	// Bus sequencer: reads take two wait states, writes none
	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			LPM_BUS_IDLE: begin
				if (rd_accept) begin
					next_bus_state = LPM_BUS_RD1;
				end
			end
			LPM_BUS_RD1: begin
				next_bus_state = LPM_BUS_RD2;
			end
			LPM_BUS_RD2: begin
				next_bus_state = LPM_BUS_IDLE;
			end
			default: begin
				next_bus_state = LPM_BUS_IDLE;
			end
		endcase
	end

	// Bus state, captured address and ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= LPM_BUS_IDLE;
			addr_q <= 8'h00;
			wr_pend <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			bus_state <= next_bus_state;
			if (addr_accept) begin
				addr_q <= haddr[7:0];
			end
			wr_pend <= wr_accept;
			hreadyout <= !(rd_accept || (bus_state == LPM_BUS_IDLE ? 1'b0 : next_bus_state != LPM_BUS_IDLE));
		end
	end

	// Read data selection
	wire logic [7:0] seg_rd = seg_implemented ? seg_en[seg_index] : 8'h00;
	wire logic [7:0] status_rd = {4'h0, in_interval_a, data_write_allowed, module_active, irq_status};
	wire logic [7:0] rd_sel = hit_ladder ? (ladder_power_control & LPM_LADDER_WMASK)
		: hit_control ? control
		: hit_status ? status_rd
		: hit_mask ? {7'h00, irq_mask}
		: hit_seg ? seg_rd
		: hit_pix ? pix_rd
		: 8'h00;

	// Read data register, loaded as the last wait state ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_state == LPM_BUS_RD2) begin
			hrdata <= {24'h00_0000, rd_sel};
		end
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// Ladder control and waveform type registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ladder_power_control <= LPM_RST_LADDER;
			control <= LPM_RST_CONTROL;
		end else if (wr_now) begin
			if (hit_ladder) begin
				ladder_power_control <= wbyte & LPM_LADDER_WMASK;
			end
			if (hit_control) begin
				control <= {wbyte[LPM_CTL_WAVE_BIT], 7'h00};
			end
		end
	end

	// Segment enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int k = 0; k < LPM_SEG_REGS; k++) begin
				seg_en[k] <= LPM_RST_SEG;
			end
		end else if (wr_now && seg_implemented) begin
			seg_en[seg_index] <= wbyte;
		end
	end

	// Interrupt mask and sticky status; a new error wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask <= LPM_RST_IRQ;
			irq_status <= LPM_RST_IRQ;
		end else begin
			if (wr_now && hit_mask) begin
				irq_mask <= wbyte[LPM_IRQ_BITS-1:0];
			end
			if (pix_wr_refused) begin
				irq_status[LPM_ST_DATA_WRITE_ERROR_BIT] <= 1'b1;
			end else if (wr_now && hit_status && wbyte[LPM_ST_DATA_WRITE_ERROR_BIT]) begin
				irq_status[LPM_ST_DATA_WRITE_ERROR_BIT] <= 1'b0;
			end
		end
	end

	// Interrupt output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// Interval scheduler fields
	wire logic [1:0] a_sel = ladder_power_control[LPM_LAD_A_MSB:LPM_LAD_A_LSB];
	wire logic [1:0] b_sel = ladder_power_control[LPM_LAD_B_MSB:LPM_LAD_B_LSB];
	wire logic [2:0] a_len = ladder_power_control[LPM_LAD_LEN_MSB:LPM_LAD_LEN_LSB];
	wire logic wave_type_b = control[LPM_CTL_WAVE_BIT];
	wire logic [4:0] seg_last = wave_type_b ? LPM_TYPE_B_LAST : LPM_TYPE_A_LAST;

	// Counter restarts on each transition and wraps at the segment time
	always_comb begin
		next_interval_cnt = interval_cnt;
		if (wave_transition) begin
			next_interval_cnt = 5'h00;
		end else if (lcd_tick) begin
			if (interval_cnt >= seg_last) begin
				next_interval_cnt = 5'h00;
			end else begin
				next_interval_cnt = interval_cnt + 5'h01;
			end
		end
	end

	// Interval counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interval_cnt <= 5'h00;
		end else begin
			interval_cnt <= next_interval_cnt;
		end
	end

	// Interval A while count is below the programmed length; zero length stays in B
	wire logic next_in_a = (a_len != 3'h0) && (next_interval_cnt < {2'b00, a_len});
	wire logic [1:0] next_power = !module_active ? LPM_PWR_OFF
		: next_in_a ? a_sel
		: b_sel;

	// Ladder power outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ladder_power <= LPM_PWR_OFF;
			in_interval_a <= 1'b0;
		end else begin
			ladder_power <= next_power;
			in_interval_a <= next_in_a && module_active;
		end
	end

	// Pixel map: byte x drives line x/6, segments 8*(x mod 6)..+7
	logic [LPM_LINES*LPM_SEGS-1:0] next_pixel;
	always_comb begin
		next_pixel = '0;
		for (int x = 0; x < LPM_PIX_REGS; x++) begin
			if (!REDUCED_PINS || (x % LPM_SEG_REGS) < LPM_REDUCED_SEG_REGS) begin
				next_pixel[(x / LPM_SEG_REGS) * LPM_SEGS + (x % LPM_SEG_REGS) * 8 +: 8] = pix_store[x*8 +: 8];
			end else if ((x % LPM_SEG_REGS) == LPM_REDUCED_SEG_REGS) begin
				next_pixel[(x / LPM_SEG_REGS) * LPM_SEGS + (x % LPM_SEG_REGS) * 8] = pix_store[x*8];
			end
		end
	end

	// Segment enable flat view
	logic [LPM_SEGS-1:0] next_drive;
	always_comb begin
		next_drive = '0;
		for (int k = 0; k < LPM_SEG_REGS; k++) begin
			next_drive[k*8 +: 8] = seg_en[k];
		end
	end

	// Glass outputs: a set bit makes the pin a segment driver, or a pixel dark where its segment pin drives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			glass_drive_on <= '0;
			pixel_bit <= '0;
		end else begin
			glass_drive_on <= next_drive;
			pixel_bit <= next_pixel;
		end
	end
endmodule : lpm_lcd_ladder

// >>> lpm_pkg.sv
// Package with register map, field layout, reset values and timing for the LCD ladder and pixel block
package lpm_pkg;
	// Register byte addresses
	localparam logic [7:0] LPM_ADDR_LADDER = 8'h00;
	localparam logic [7:0] LPM_ADDR_CONTROL = 8'h04;
	localparam logic [7:0] LPM_ADDR_STATUS = 8'h08;
	localparam logic [7:0] LPM_ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] LPM_ADDR_SEG_BASE = 8'h40;
	localparam logic [7:0] LPM_ADDR_PIX_BASE = 8'h80;
	localparam logic [7:0] LPM_ADDR_PIX_LAST = 8'hDC;
	// Ladder control fields
	localparam int LPM_LAD_A_MSB = 7;
	localparam int LPM_LAD_A_LSB = 6;
	localparam int LPM_LAD_B_MSB = 5;
	localparam int LPM_LAD_B_LSB = 4;
	localparam int LPM_LAD_UNUSED_BIT = 3;
	localparam int LPM_LAD_LEN_MSB = 2;
	localparam int LPM_LAD_LEN_LSB = 0;
	localparam logic [7:0] LPM_LADDER_WMASK = 8'hF7;
	// Control and status fields
	localparam int LPM_CTL_WAVE_BIT = 7;
	localparam int LPM_ST_DATA_WRITE_ERROR_BIT = 0;
	localparam int LPM_ST_ACTIVE_BIT = 1;
	localparam int LPM_ST_ALLOW_BIT = 2;
	localparam int LPM_ST_INA_BIT = 3;
	localparam int LPM_IRQ_BITS = 1;
	// Reset values
	localparam logic [7:0] LPM_RST_LADDER = 8'h00;
	localparam logic [7:0] LPM_RST_CONTROL = 8'h00;
	localparam logic [7:0] LPM_RST_SEG = 8'h00;
	localparam logic [7:0] LPM_RST_PIX = 8'h00;
	localparam logic [LPM_IRQ_BITS-1:0] LPM_RST_IRQ = 1'h0;
	// Geometry
	localparam int LPM_SEG_REGS = 6;
	localparam int LPM_LINES = 4;
	localparam int LPM_PIX_REGS = 24;
	localparam int LPM_SEGS = 48;
	localparam int LPM_REDUCED_SEG_REGS = 4;
	// Segment time last counts (lengths minus one) in LCD clock counts
	localparam logic [4:0] LPM_TYPE_A_LAST = 5'h0F;
	localparam logic [4:0] LPM_TYPE_B_LAST = 5'h1F;
	// Ladder power codes
	localparam logic [1:0] LPM_PWR_OFF = 2'h0;
	localparam logic [1:0] LPM_PWR_HIGH = 2'h3;
	// Bus transfer states
	typedef enum logic [1:0] {
		LPM_BUS_IDLE = 2'b00,
		LPM_BUS_RD1 = 2'b01,
		LPM_BUS_RD2 = 2'b10
	} lpm_bus_state_t;
endpackage : lpm_pkg

// >>> lpm_pixel_mem.sv
// Pixel data storage: 24 byte registers, one write port, registered read port, flat view
`timescale 1ns/1ps
module lpm_pixel_mem
	import lpm_pkg::*;
#(
	parameter int DEPTH = 24,
	parameter int AW = 5
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_index,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_index,
	output logic [7:0] rd_data,
	output logic [DEPTH*8-1:0] contents
);
	logic [7:0] mem [DEPTH];

	// Storage, cleared at every reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= LPM_RST_PIX;
			end
		end else if (wr_en) begin
			mem[wr_index] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data <= LPM_RST_PIX;
		end else begin
			rd_data <= mem[rd_index];
		end
	end

	// Flat view of every stored byte
	always_comb begin
		contents = '0;
		for (int i = 0; i < DEPTH; i++) begin
			contents[i*8 +: 8] = mem[i];
		end
	end
endmodule : lpm_pixel_mem

// >>> lpm_glass.sv
// Passive glass model: a pixel shows dark only where its segment pin drives the glass
`timescale 1ns/1ps
module lpm_glass
	import lpm_pkg::*;
(
	input wire logic [LPM_SEGS-1:0] glass_drive_on,
	input wire logic [LPM_LINES*LPM_SEGS-1:0] pixel_bit,
	output logic [LPM_LINES*LPM_SEGS-1:0] dark
);
	// Pins left as digital I/O never darken a pixel
	assign dark = pixel_bit & {LPM_LINES{glass_drive_on}};
endmodule : lpm_glass

// >>> lpm_lcd_ladder_assertions.sv
// Checker of bus timing, ladder scheduling and output causes at the block's ports
`timescale 1ns/1ps
module lpm_lcd_ladder_checker
	import lpm_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic lcd_tick,
	input wire logic wave_transition,
	input wire logic module_active,
	input wire logic [1:0] ladder_power,
	input wire logic in_interval_a,
	input wire logic [LPM_SEGS-1:0] glass_drive_on,
	input wire logic [LPM_LINES*LPM_SEGS-1:0] pixel_bit
);
	logic [3:0] a_ticks;
	wire taken = hsel && htrans[1] && hready;
	wire wr_taken = taken && hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Counts ticks spent in interval A; a restart begins a new count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ticks <= 4'h0;
		end else if (!in_interval_a || wave_transition) begin
			a_ticks <= 4'h0;
		end else if (lcd_tick) begin
			a_ticks <= a_ticks + 4'h1;
		end
	end
	sequence s_rd_wait;
		!hreadyout ##1 !hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (taken && !hwrite |=> s_rd_wait) else $error("read wait states wrong");
	a_write_nowait: assert property (wr_taken |=> hreadyout) else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_inactive_off: assert property (!module_active [*2] |-> ladder_power == LPM_PWR_OFF)
		else $error("ladder powered while inactive");
	a_inactive_no_a: assert property (!module_active [*2] |-> !in_interval_a)
		else $error("interval A while inactive");
	a_interval_a_max: assert property (a_ticks <= 4'h7) else $error("interval A too long");
	// A write taken at one edge lands in the register at the next and reaches the pins one later
	a_seg_cause: assert property (!$stable(glass_drive_on) |-> $past(wr_taken, 3))
		else $error("segment enables changed without a write");
	a_pix_cause: assert property (!$stable(pixel_bit) |-> $past(wr_taken, 3))
		else $error("pixels changed without a write");
endmodule : lpm_lcd_ladder_checker
bind lpm_lcd_ladder lpm_lcd_ladder_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.lcd_tick(lcd_tick), .wave_transition(wave_transition), .module_active(module_active),
	.ladder_power(ladder_power), .in_interval_a(in_interval_a), .glass_drive_on(glass_drive_on),
	.pixel_bit(pixel_bit));

// >>> lpm_lcd_ladder_test.sv
// Self-checking testbench of the LCD ladder and pixel block
`timescale 1ns/1ps
module lpm_lcd_ladder_test
	import lpm_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lcd_tick = 0, wave_transition = 0;
	logic module_active = 0, data_write_allowed = 0, hready;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, hrdata_r, r, r_red, v, seed = 32'h0000_004E;
	logic [1:0] htrans = 0, ladder_power, a, b;
	logic [2:0] hsize = 0;
	logic hreadyout, hresp, in_interval_a, irq;
	logic [LPM_SEGS-1:0] glass_drive_on, glass_drive_on_r;
	logic [LPM_LINES*LPM_SEGS-1:0] pixel_bit, dark, pixel_bit_r;
	int err_count = 0, n_compared = 0, n, per, base, col;
	assign hready = hreadyout;
	lpm_lcd_ladder i_lpm_lcd_ladder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lcd_tick(lcd_tick),
		.wave_transition(wave_transition), .module_active(module_active),
		.data_write_allowed(data_write_allowed), .ladder_power(ladder_power),
		.in_interval_a(in_interval_a), .glass_drive_on(glass_drive_on), .pixel_bit(pixel_bit), .irq(irq));
	lpm_glass i_lpm_glass (.glass_drive_on(glass_drive_on), .pixel_bit(pixel_bit), .dark(dark));
	// Reduced-pin variant on the same bus; it answers in lockstep, so the shared ready suits it
	lpm_lcd_ladder #(.REDUCED_PINS(1'b1)) i_lpm_lcd_ladder_reduced (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata_r), .hreadyout(), .hresp(), .lcd_tick(lcd_tick), .wave_transition(wave_transition),
		.module_active(module_active), .data_write_allowed(data_write_allowed), .ladder_power(),
		.in_interval_a(), .glass_drive_on(glass_drive_on_r), .pixel_bit(pixel_bit_r), .irq());
	// Clock of 10 ns
	always #5 hclk = ~hclk;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Power expected at a tick count since the last transition
	function logic [1:0] exp_pwr(input int i);
		return (n != 0 && (i % per) < n) ? a : b;
	endfunction : exp_pwr
	task chk(input string nm, input logic [191:0] seen, input logic [191:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One single AHB transfer; read data lands in r
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0000_00, ad};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		r_red = hrdata_r;
	endtask : bus
	// Transition pulse or tick pulse, then settle
	task step(input logic wt);
		@(posedge hclk);
		wave_transition <= wt;
		lcd_tick <= !wt;
		@(posedge hclk);
		wave_transition <= 1'b0;
		lcd_tick <= 1'b0;
		@(posedge hclk);
		#1;
	endtask : step
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	initial begin
		#200000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			bus(1'b0, (i == 0) ? 8'h00 : (i < 7) ? 8'h3C + 8'(4*i) : (i < 31) ? 8'h64 + 8'(4*i) : 8'hF0, 0);
			chk("reset value", r, 0);
			chk("reduced reset value", r_red, 0);
		end
		bus(1'b1, LPM_ADDR_LADDER, 32'h0000_00FF);
		bus(1'b0, LPM_ADDR_LADDER, 0);
		chk("ladder bit3", r, 32'h0000_00F7);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			v = rnd() & 32'h0000_00FF;
			bus(1'b1, LPM_ADDR_SEG_BASE + 8'(4*k), v);
			bus(1'b0, LPM_ADDR_SEG_BASE + 8'(4*k), 0);
			chk("segment reg", r, v);
			chk("drive pins", glass_drive_on[8*k +: 8], v);
			chk("reduced segment reg", r_red, (k < 4) ? v : 32'h0000_0000);
			chk("reduced drive pins", glass_drive_on_r[8*k +: 8], (k < 4) ? v : 32'h0000_0000);
		end
		data_write_allowed <= 1'b1;
		for (int x = 0; x < 24; x++) begin
			v = rnd() & 32'h0000_00FF;
			base = (x / 6) * 48 + 8 * (x % 6);
			col = x % 6;
			bus(1'b1, LPM_ADDR_PIX_BASE + 8'(4*x), v);
			bus(1'b0, LPM_ADDR_PIX_BASE + 8'(4*x), 0);
			chk("pixel reg", r, v);
			chk("pixel map", pixel_bit[base +: 8], v);
			chk("glass dark", dark[base +: 8], v[7:0] & glass_drive_on[8*(x%6) +: 8]);
			chk("reduced pixel reg", r_red, (col == 4) ? (v & 32'h0000_0001) : v);
			chk("reduced pixel map", pixel_bit_r[base +: 8],
				(col < 4) ? v : (col == 4) ? (v & 32'h0000_0001) : 32'h0000_0000);
		end
		$display("test map done");
		data_write_allowed <= 1'b0;
		v = {24'h00_0000, pixel_bit[7:0]};
		bus(1'b1, LPM_ADDR_PIX_BASE, ~v);
		bus(1'b1, LPM_ADDR_IRQ_MASK, 1);
		bus(1'b0, LPM_ADDR_STATUS, 0);
		chk("write error", r[LPM_ST_DATA_WRITE_ERROR_BIT], 1);
		chk("refused pixel", pixel_bit[7:0], v[7:0]);
		chk("irq raised", irq, 1);
		bus(1'b1, LPM_ADDR_IRQ_MASK, 0);
		bus(1'b0, LPM_ADDR_STATUS, 0);
		chk("irq masked", irq, 0);
		chk("error sticky", r[LPM_ST_DATA_WRITE_ERROR_BIT], 1);
		bus(1'b1, LPM_ADDR_IRQ_MASK, 1);
		bus(1'b1, LPM_ADDR_STATUS, 1);
		bus(1'b0, LPM_ADDR_STATUS, 0);
		chk("error cleared", r[LPM_ST_DATA_WRITE_ERROR_BIT], 0);
		chk("irq cleared", irq, 0);
		$display("test error done");
		module_active <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			for (int j = 0; j < 4; j++) begin
				n = (j == 0) ? 0 : (j == 1) ? 1 : (j == 2) ? 7 : int'(rnd() % 8);
				a = j[1:0];
				b = 2'(rnd());
				per = t ? 32 : 16;
				bus(1'b1, LPM_ADDR_CONTROL, t << LPM_CTL_WAVE_BIT);
				bus(1'b1, LPM_ADDR_LADDER, {24'h0000_00, a, b, 1'b0, 3'(n)});
				step(1'b1);
				for (int i = 0; i <= per; i++) begin
					if (i > 0)
						step(1'b0);
					chk("ladder power", ladder_power, exp_pwr(i));
					chk("interval a", in_interval_a, n != 0 && (i % per) < n);
				end
			end
		end
		module_active <= 1'b0;
		step(1'b1);
		chk("inactive power", ladder_power, LPM_PWR_OFF);
		$display("test ladder done");
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk("reset pins", glass_drive_on, 0);
		chk("reset pixels", pixel_bit, 0);
		$display("test second reset done");
		final_report;
	end
endmodule : lpm_lcd_ladder_test
